// *** verilog/imr_cfg.svh ***
/*
  Constants for the mode and rate block: register offsets, field positions,
  reset values and divider table. Assumes inclusion by bare name.
*/
`ifndef IMR_CFG_SVH
`define IMR_CFG_SVH
`define IMR_OFF_MODE_RATE   8'h00
`define IMR_OFF_CTRL        8'h04
`define IMR_OFF_EXT         8'h08
`define IMR_OFF_STATUS      8'h0c
`define IMR_BIT_ORDER_POS   7
`define IMR_WAIT_POS        6
`define IMR_RATE_HI         5
`define IMR_RATE_LO         3
`define IMR_COUNT_HI        2
`define IMR_COUNT_LO        0
`define IMR_CTRL_ENABLE_POS 7
`define IMR_CTRL_MASTER_POS 5
`define IMR_CTRL_IRQ_POS    0
`define IMR_EXT_RANGE_POS   1
`define IMR_EXT_FMTB_POS    0
`define IMR_MODE_RATE_RST   8'h00
`define IMR_EXT_RST         8'h01
`define IMR_DIV_R0 {9'd128,9'd112,9'd100,9'd80,9'd64,9'd48,9'd40,9'd28}
`define IMR_DIV_R1 {9'd256,9'd224,9'd200,9'd160,9'd128,9'd96,9'd80,9'd56}
`endif

// *** verilog/imr_pkg.sv ***
/*
  Types for the mode and rate block. Assumes nothing of its surroundings.
*/
package imr_pkg;
  typedef struct packed {
    logic       bit_order;  // 0 msb first
    logic       wait_ins;   // Wait after data bits
    logic [2:0] rate_sel;   // Divider select
    logic [2:0] frame_cnt;  // Bits per frame code
  } imr_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOW   = 4'b0010,
    ST_HIGH  = 4'b0100,
    ST_STALL = 4'b1000
  } imr_state_t;
endpackage : imr_pkg

// *** verilog/imr_core.sv ***
/*
  Mode and rate register block of a two-wire serial interface, with an
  AXI4-Lite slave, bit-rate divider, frame bit counter and wait stall.
  Assumes a single 100 MHz clock, synchronous active-low reset, and that
  sda_in is already synchronous to aclk.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Overview of operation
// - Mode and rate register reachable only while the enable bit is set.
// - Shift msb first when bit order is 0, lsb first when 1.
// - Wait insertion acts only as master in bus format.
// - Without wait, data bits and acknowledge go back to back.
// - Clearing the flag during a wait releases clock, acknowledge follows.
// - Master clock divides the peripheral clock by the selected table entry.
// - Counter clears on start condition and after a whole frame.
// - Frame count code maps to bits per frame per format.
// - Both format bits set select synchronous serial, else bus format.
// - Short frames align transmit data high or low by bit order.
// - With enable clear, block idles and clears transfer state.
`include "imr_cfg.svh"
module imr_core (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read response valid
  input  wire logic        s_axi_rready,  // Read response ready
  input  wire logic        format_select_a, // Format bit from address reg
  input  wire logic        start_det,     // Start condition seen
  input  wire logic        frame_go,      // Begin a frame as master
  input  wire logic [7:0]  tx_byte,       // Transmit data
  input  wire logic        sda_in,        // Data line level
  output logic             scl_out,       // Clock line drive
  output logic             scl_oe,        // Clock line driven low
  output logic             sda_out,       // Data line drive
  output logic             sda_oe,        // Data line enable
  output logic [7:0]       rx_byte,       // Received data
  output logic             frame_done,    // Frame complete pulse
  output logic             iface_irq_flag // Interrupt flag
);
  // Divider tables, nine bits per entry, entry 0 in the low bits
  wire [71:0] div_tab_r0 = `IMR_DIV_R0;
  wire [71:0] div_tab_r1 = `IMR_DIV_R1;

  imr_pkg::imr_mode_t  mode_q;
  imr_pkg::imr_state_t st_q;
  logic       iface_enable_q, master_q, irq_q;
  logic       rate_range_bit_q, format_select_b_q;
  logic [7:0] sh_q, rx_q;
  logic [3:0] cnt_q;
  logic [8:0] div_q;
  logic       aw_q, w_q, bv_q, rv_q;
  logic       ws_q;                         // Lane 0 strobe of the write
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] br_q, rr_q;
  logic       done_q;

  // Format, frame length and divider selection
  wire        sync_fmt  = format_select_a & format_select_b_q;
  wire [2:0]  code      = mode_q.frame_cnt;
  wire [3:0]  nbits     = sync_fmt ? ((code == 3'd0) ? 4'd8 : {1'b0, code})
                                   : ((code == 3'd0) ? 4'd9
                                      : {1'b0, code} + 4'd1);
  wire        wait_on   = mode_q.wait_ins & master_q & ~sync_fmt;
  wire [8:0]  div_full  = rate_range_bit_q
                          ? div_tab_r1[9*mode_q.rate_sel +: 9]
                          : div_tab_r0[9*mode_q.rate_sel +: 9];
  wire [8:0]  half      = {1'b0, div_full[8:1]};
  wire        tick      = (div_q == half - 9'd1);
  // Acknowledge bit of a bus-format frame: follows the last data clock
  wire        ack_bit   = (cnt_q == nbits - 4'd1) & ~sync_fmt;
  wire        last_bit  = (cnt_q == nbits - 4'd1);
  wire        tx_bit    = mode_q.bit_order ? sh_q[0] : sh_q[7];
  // Short frames: data placed msb-side or lsb-side per bit order
  wire [7:0]  rx_in     = mode_q.bit_order ? {sda_in, rx_q[7:1]}
                                           : {rx_q[6:0], sda_in};

  // Bus decode
  wire        wr_go     = aw_q & w_q & ~bv_q;
  wire        wr_mr     = wr_go & (awa_q == `IMR_OFF_MODE_RATE)
                          & iface_enable_q;
  wire        wr_ctrl   = wr_go & (awa_q == `IMR_OFF_CTRL);
  wire        wr_ext    = wr_go & (awa_q == `IMR_OFF_EXT);
  wire        wr_ok     = wr_mr | wr_ctrl | wr_ext
                          | (wr_go & awa_q == `IMR_OFF_STATUS);
  wire        rd_go     = s_axi_arvalid & ~rv_q;
  wire        rd_mr     = s_axi_araddr == `IMR_OFF_MODE_RATE;
  wire        rd_mr_ok  = rd_mr & iface_enable_q;
  wire        irq_clr   = wr_ctrl & ~wd_q[`IMR_CTRL_IRQ_POS];
  wire        irq_set   = (st_q == imr_pkg::ST_LOW) & tick & ack_bit
                          & wait_on;
  wire [31:0] rd_mux    =
    rd_mr ? {24'h0, mode_q} :
    (s_axi_araddr == `IMR_OFF_CTRL) ? {24'h0, iface_enable_q, 1'b0,
                                       master_q, 4'h0, irq_q} :
    (s_axi_araddr == `IMR_OFF_EXT) ? {30'h0, rate_range_bit_q,
                                      format_select_b_q} :
    {27'h0, sync_fmt, cnt_q};
  wire        rd_known  = (rd_mr_ok | s_axi_araddr == `IMR_OFF_CTRL
                           | s_axi_araddr == `IMR_OFF_EXT
                           | s_axi_araddr == `IMR_OFF_STATUS);

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ~rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign scl_out       = 1'b0;
  assign scl_oe        = (st_q == imr_pkg::ST_LOW)
                         | (st_q == imr_pkg::ST_STALL);
  assign sda_out       = 1'b0;
  // Data line released for the acknowledge bit, whatever the frame length
  assign sda_oe        = (st_q != imr_pkg::ST_IDLE) & ~tx_bit & ~ack_bit;
  assign rx_byte       = rx_q;
  assign frame_done    = done_q;
  assign iface_irq_flag = irq_q;

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; br_q <= 2'b00;
      awa_q <= 8'h00; wd_q <= 32'h0; ws_q <= 1'b0;
    end else begin
      if (s_axi_awvalid & ~aw_q) begin aw_q <= 1'b1; awa_q <= s_axi_awaddr; end
      if (s_axi_wvalid & ~w_q) begin
        w_q <= 1'b1; wd_q <= s_axi_wdata; ws_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin bv_q <= 1'b1; br_q <= wr_ok ? 2'b00 : 2'b10; end
      if (bv_q & s_axi_bready) begin bv_q <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0; end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'b00;
    end else if (rd_go) begin
      rv_q <= 1'b1;
      rd_q <= rd_known ? rd_mux : 32'h0;
      rr_q <= rd_known ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end

  // Register bank; set of the flag wins over a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      mode_q <= `IMR_MODE_RATE_RST;
      iface_enable_q <= 1'b0; master_q <= 1'b0; irq_q <= 1'b0;
      {rate_range_bit_q, format_select_b_q} <= 2'(`IMR_EXT_RST);
    end else begin
      if (wr_mr && ws_q) mode_q <= wd_q[7:0];
      if (wr_ctrl && ws_q) begin
        iface_enable_q <= wd_q[`IMR_CTRL_ENABLE_POS];
        master_q <= wd_q[`IMR_CTRL_MASTER_POS];
      end
      if (wr_ext && ws_q) begin
        rate_range_bit_q  <= wd_q[`IMR_EXT_RANGE_POS];
        format_select_b_q <= wd_q[`IMR_EXT_FMTB_POS];
      end
      if (irq_set) irq_q <= 1'b1;
      else if (irq_clr) irq_q <= 1'b0;
    end
  end

  // Divider, bit counter and shift engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !iface_enable_q || start_det) begin
      st_q <= imr_pkg::ST_IDLE;
      cnt_q <= 4'd0;
      div_q <= 9'd0; sh_q <= 8'h00; rx_q <= 8'h00; done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      div_q <= tick ? 9'd0 : div_q + 9'd1;
      case (st_q)
        imr_pkg::ST_IDLE:
          if (frame_go & master_q) begin
            st_q <= imr_pkg::ST_LOW; sh_q <= tx_byte; div_q <= 9'd0;
          end
        imr_pkg::ST_LOW:
          if (tick)
            st_q <= (ack_bit & wait_on) ? imr_pkg::ST_STALL
                                        : imr_pkg::ST_HIGH;
        // Divider held at zero so the released high half is a full one
        imr_pkg::ST_STALL:
          begin
            div_q <= 9'd0;
            if (!irq_q) st_q <= imr_pkg::ST_HIGH;
          end
        imr_pkg::ST_HIGH:
          if (tick) begin
            if (!ack_bit) rx_q <= rx_in;
            sh_q <= mode_q.bit_order ? {1'b1, sh_q[7:1]} : {sh_q[6:0], 1'b1};
            if (last_bit) begin
              cnt_q <= 4'd0; done_q <= 1'b1; st_q <= imr_pkg::ST_IDLE;
            end else begin
              cnt_q <= cnt_q + 4'd1;
              st_q <= imr_pkg::ST_LOW;
            end
          end
        default: st_q <= imr_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : imr_core

// *** bench/imr_assertions.sv ***
/* Port checker of the mode and rate block.
   Assumes a bind to imr_core and one clock domain. */
module imr_assertions (
  input wire logic        aclk,           // Clock
  input wire logic        aresetn,        // Reset, low
  input wire logic        s_axi_bvalid,   // Write answer
  input wire logic        s_axi_bready,   // Answer taken
  input wire logic        s_axi_rvalid,   // Read answer
  input wire logic        s_axi_rready,   // Answer taken
  input wire logic [1:0]  s_axi_rresp,    // Read code
  input wire logic [31:0] s_axi_rdata,    // Read data
  input wire logic [7:0]  s_axi_araddr,   // Read address
  input wire logic        s_axi_arvalid,  // Address valid
  input wire logic        s_axi_arready,  // Address ready
  input wire logic        start_det,      // Start seen
  input wire logic        frame_go,       // Frame begin
  input wire logic        scl_oe,         // Clock held low
  input wire logic        frame_done,     // Frame end
  input wire logic        iface_irq_flag  // Flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10 |=>
      s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("bad unmapped");
  property p_pulse; frame_done |=> !frame_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_start; start_det && !frame_go |=> !scl_oe; endproperty
  a_start: assert property (p_start) else $error("start no clear");
  property p_low; $rose(scl_oe) |-> scl_oe [*8]; endproperty
  a_low: assert property (p_low) else $error("low too short");
  property p_high; $fell(scl_oe) && !start_det |-> !scl_oe [*8]; endproperty
  a_high: assert property (p_high) else $error("high too short");
  property p_stall; $rose(iface_irq_flag) |-> scl_oe [*8]; endproperty
  a_stall: assert property (p_stall) else $error("no stall");
endmodule : imr_assertions

// *** bench/imr_partner.sv ***
/* Receiving bus device on the data line.
   Assumes the block's open-drain drives and a pull-up on data. */
module imr_partner (
  input  wire logic aclk,   // Clock
  input  wire logic clr,    // New frame
  input  wire logic scl_oe, // Clock low
  input  wire logic sda_oe, // Data low
  output logic      sda_in  // Line level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bit_q;
  logic       oe_q;
  // Count bits; the ninth is pulled low as acknowledge
  always_ff @(posedge aclk)
  begin
    oe_q <= scl_oe;
    if (clr)
      bit_q <= 4'h0;
    else if (scl_oe && !oe_q)
      bit_q <= bit_q + 4'h1;
  end
  // Wired-AND with the pull-up
  assign sda_in = !(sda_oe || bit_q == 4'h9);
endmodule : imr_partner

// *** bench/tb_top.sv ***
/* Self-checking bench of the mode and rate block.
   Assumes imr_core and the two bench models. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
  typedef struct packed {
    logic [3:0] n;
    logic [3:0] nd;
    logic [7:0] half;
    logic [7:0] bits;
    logic [7:0] rx;
  } imr_fexp_t;
  localparam int DIVS [16] = '{28, 40, 48, 64, 80, 100, 112, 128,
    56, 80, 96, 128, 160, 200, 224, 256};
  logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0;
  logic        bready = '0, arvalid = '0, rready = '0, fsa = '0;
  logic        start_det = '0, frame_go = '0, oe_d = '0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
  logic        sda_in, frame_done, irq;
  logic [7:0]  rxb;
  logic [7:0]  awaddr = '0, araddr = '0, tx = '0, lowc = '0, bits = '0;
  logic [31:0] wdata = '0, rdata, seed = 32'h38;
  logic [1:0]  bresp, rresp, eb;
  logic [3:0]  rises = '0;
  logic [33:0] er;
  int          tests_run = 0, failures = 0, i;
  logic [1:0]  exp_b [$];
  logic [33:0] exp_r [$];
  imr_fexp_t   exp_f [$], ef;
  imr_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .format_select_a(fsa), .start_det(start_det),
    .frame_go(frame_go), .tx_byte(tx), .sda_in(sda_in), .scl_out(),
    .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .rx_byte(rxb),
    .frame_done(frame_done), .iface_irq_flag(irq));
  imr_partner pm_u (.aclk(aclk), .clr(start_det), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .sda_in(sda_in));
  always #5 aclk = ~aclk;
  // Compare each answer and each frame with the oldest note
  always @(posedge aclk)
  begin
    if (bvalid && bready)
    begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
    if (rvalid && rready)
    begin
      er = exp_r.pop_front();
      `CHK({rresp, rdata}, er)
    end
    oe_d <= scl_oe;
    if (scl_oe && !oe_d)
      rises <= rises + 4'h1;
    if (scl_oe && (rises == 4'h0 || (rises == 4'h1 && oe_d)))
      lowc <= lowc + 8'h1;
    if (!scl_oe && oe_d && exp_f.size() != 0 && rises <= exp_f[0].nd)
      bits <= {bits[6:0], !sda_oe};
    if (frame_done)
    begin
      ef = exp_f.pop_front();
      `CHK(rises, ef.n)
      `CHK(lowc, ef.half)
      `CHK(bits, ef.bits)
      `CHK(rxb, ef.rx)
      rises <= '0;
      lowc <= '0;
      bits <= '0;
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    if (w) exp_b.push_back(r);
    else exp_r.push_back({r, d});
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid) && n < 99);
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 99)
    begin
      failures++;
      stop_test();
    end
    @(posedge aclk);
  endtask : bus
  task automatic frame(input logic [3:0] sel, input logic [2:0] c,
                       input logic sy, input logic wt);
    logic [7:0] t;
    logic       o, st;
    int         nb, k, n;
    imr_fexp_t  e;
    t = rnd();
    o = sy & t[3];
    nb = c == 3'h0 ? (sy ? 8 : 9) : (sy ? int'(c) : int'(c) + 1);
    e.n = 4'(nb);
    e.nd = 4'(sy ? nb : nb - 1);
    e.half = 8'(DIVS[sel] / 2);
    e.bits = '0;
    // Received bits land at the lsb side for msb first, else msb side
    e.rx = o ? t << (8 - e.nd) : t >> (8 - e.nd);
    for (k = 0; k < e.nd; k++) e.bits = {e.bits[6:0], o ? t[k] : t[7 - k]};
    fsa <= sy;
    bus(1'b1, 8'h08, {30'h0, sel[3], 1'b1}, 2'h0);
    bus(1'b1, 8'h00, {24'h0, o, wt, sel[2:0], c}, 2'h0);
    bus(1'b0, 8'h00, {24'h0, o, wt, sel[2:0], c}, 2'h0);
    start_det <= 1'b1;
    @(posedge aclk);
    start_det <= 1'b0;
    exp_f.push_back(e);
    tx <= t;
    frame_go <= 1'b1;
    @(posedge aclk);
    frame_go <= 1'b0;
    n = 0;
    st = 1'b0;
    while (exp_f.size() != 0 && n < 9000)
    begin
      @(posedge aclk);
      n++;
      if (irq && !sy)
      begin
        st = 1'b1;
        repeat (20) @(posedge aclk);
        `CHK(scl_oe, 1'b1)
        bus(1'b1, 8'h04, 32'ha0, 2'h0);
      end
    end
    if (n >= 9000)
    begin
      failures++;
      stop_test();
    end
    `CHK(st, wt & !sy)
    bus(1'b0, 8'h0c, {27'h0, sy, 4'h0}, 2'h0);
    $display("frame test %0h done", sel);
  endtask : frame
  // Main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus(1'b0, 8'h00, 32'h0, 2'h2);
    bus(1'b1, 8'h00, 32'hff, 2'h2);
    bus(1'b0, 8'h08, 32'h1, 2'h0);
    bus(1'b1, 8'h04, 32'ha0, 2'h0);
    bus(1'b0, 8'h00, 32'h0, 2'h0);
    bus(1'b0, 8'h10, 32'h0, 2'h2);
    $display("register test done");
    for (i = 0; i < 16; i++) frame(4'(i), 3'(rnd()), i[0], i[0]);
    frame(4'h0, 3'h0, 1'b0, 1'b1);
    frame(4'hf, 3'h0, 1'b1, 1'b0);
    stop_test();
  end
endmodule : tb_top
bind imr_core imr_assertions chk_u (.*);
